// ===== gripper_defs.svh
// constants for the gripper modbus rtu slave
`ifndef GRIPPER_DEFS_SVH
`define GRIPPER_DEFS_SVH

// timing
`define CLK_HZ 125000000
`define CLK_MHZ 125
`define BAUD_DEFAULT 115200
`define FRAME_GAP_US 1750

// link identity and functions
`define SLAVE_ADDR_DEFAULT 8'h09
`define FC_READ_INPUT 8'h04
`define FC_PRESET_MULTI 8'h10
`define FC_READ_WRITE 8'h17

// register map, protocol word addresses
`define CMD_BASE 16'h03e8
`define REG_COMMAND_WORD_ACTION 16'h03e8
`define REG_COMMAND_WORD_POSITION_SPEED 16'h03e9
`define REG_COMMAND_WORD_FORCE 16'h03ea
`define STAT_BASE 16'h07d0
`define REG_STATUS_WORD_STATE 16'h07d0
`define REG_STATUS_WORD_FAULT_ECHO 16'h07d1

// byte arrays and frame buffer
`define CMD_BYTES 6
`define STAT_BYTES 6
`define RX_MAX 24
`define MAX_READ_REGS 16
`define CMD_RESET 8'h00

// field positions
`define BIT_ACT 0
`define BIT_GOTO 3
`define STA_LSB 4
`define OBJ_LSB 6
`define BYTE_TARGET 3
`define BYTE_SPEED 4
`define BYTE_FORCE 5

// object contact codes
`define OBJ_MOVING 2'h0
`define OBJ_STOP_OPEN 2'h1
`define OBJ_STOP_CLOSE 2'h2
`define OBJ_AT_TARGET 2'h3

// crc
`define CRC_INIT 16'hffff
`define CRC_POLY 16'ha001

`endif

// ===== gripper_pkg.sv
// types and the shared crc step for the gripper modbus slave
`include "gripper_defs.svh"
package gripper_pkg;

    typedef enum logic [1:0] {st_idle, st_exec, st_send, st_wait} link_state_e;

    // one byte of the reflected modbus crc
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_step

endpackage : gripper_pkg

// ===== modbus_uart.sv
// 8n1 serial receiver and transmitter for the rs-485 line
`timescale 1ns/1ns
module modbus_uart #(
    parameter int BIT_CYCLES = 1085
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    // line
    input wire logic rx_pin,
    output logic tx_pin,
    // receive side
    output logic rx_valid,
    output logic [7:0] rx_data,
    // transmit side
    input wire logic tx_start,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic rx_meta, rx_s, rx_busy, next_rx_busy, next_rx_valid;
    logic [15:0] rx_cnt, next_rx_cnt;
    logic [3:0] rx_bit, next_rx_bit;
    logic [7:0] next_rx_data;
    logic tx_busy, next_tx_busy, next_tx_pin;
    logic [15:0] tx_cnt, next_tx_cnt;
    logic [3:0] tx_bit, next_tx_bit;
    logic [9:0] tx_sh, next_tx_sh;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_rx_busy = rx_busy;
        next_rx_cnt = rx_cnt;
        next_rx_bit = rx_bit;
        next_rx_data = rx_data;
        next_rx_valid = 1'b0;
        if (!rx_busy) begin
            if (!rx_s) begin
                next_rx_busy = 1'b1;
                next_rx_cnt = 16'(BIT_CYCLES / 2);
                next_rx_bit = 4'h0;
            end
        end else if (rx_cnt != 16'h0000) begin
            next_rx_cnt = rx_cnt - 16'h0001;
        end else begin
            next_rx_cnt = 16'(BIT_CYCLES - 1);
            next_rx_bit = rx_bit + 4'h1;
            if (rx_bit == 4'h0) begin
                // a glitch shorter than half a bit is not a start bit
                next_rx_busy = !rx_s;
            end else if (rx_bit == 4'h9) begin
                next_rx_busy = 1'b0;
                next_rx_valid = rx_s;
            end else begin
                next_rx_data = {rx_s, rx_data[7:1]};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rx_meta <= 1'b1;
            rx_s <= 1'b1;
            rx_busy <= 1'b0;
            rx_cnt <= 16'h0000;
            rx_bit <= 4'h0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rx_meta <= rx_pin;
            rx_s <= rx_meta;
            rx_busy <= next_rx_busy;
            rx_cnt <= next_rx_cnt;
            rx_bit <= next_rx_bit;
            rx_data <= next_rx_data;
            rx_valid <= next_rx_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign tx_ready = !tx_busy;

    always_comb begin
        next_tx_busy = tx_busy;
        next_tx_cnt = tx_cnt;
        next_tx_bit = tx_bit;
        next_tx_sh = tx_sh;
        if (!tx_busy) begin
            if (tx_start) begin
                next_tx_busy = 1'b1;
                next_tx_sh = {1'b1, tx_data, 1'b0};
                next_tx_cnt = 16'(BIT_CYCLES - 1);
                next_tx_bit = 4'h0;
            end
        end else if (tx_cnt != 16'h0000) begin
            next_tx_cnt = tx_cnt - 16'h0001;
        end else begin
            next_tx_cnt = 16'(BIT_CYCLES - 1);
            next_tx_bit = tx_bit + 4'h1;
            next_tx_sh = {1'b1, tx_sh[9:1]};
            next_tx_busy = (tx_bit != 4'h9);
        end
        next_tx_pin = next_tx_busy ? next_tx_sh[0] : 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tx_busy <= 1'b0;
            tx_cnt <= 16'h0000;
            tx_bit <= 4'h0;
            tx_sh <= 10'h3ff;
            tx_pin <= 1'b1;
        end else begin
            tx_busy <= next_tx_busy;
            tx_cnt <= next_tx_cnt;
            tx_bit <= next_tx_bit;
            tx_sh <= next_tx_sh;
            tx_pin <= next_tx_pin;
        end
    end
endmodule : modbus_uart

// ===== gripper_modbus_rtu_slave.sv
// modbus rtu slave front end with object contact and brake reporting
`timescale 1ns/1ns
`include "gripper_defs.svh"
// How it works
// - contact code: 0 moving, 1 stopped opening, 2 stopped closing, 3 at target.
// - contact code only meaningful while goto echo is one; otherwise held at zero.
// - after a go-to, report moving, then 2 when stopped on contact closing.
// - a slipped object after closing contact moves the code from 2 to 3.
// - brake engages at every move end, releases between; before contact is reported.
// - addresses and counts travel high byte first, register data low byte first.
// - 115200 bps 8n1 by default, configurable; slave address taken from the slave_address input, no default.
// - only read input, preset multiple and read-write multiple; never exceptions.
// - command registers start at 0x03e8, status registers at 0x07d0.
// - each register pairs two consecutive gripper bytes, status bytes 0 and 1 first.
// - read reply is address, function, byte count, register data, crc.
// - preset applies data, replies address, function, start, count, crc.
// - every frame ends in modbus crc, checked on receipt and made on transmit.
// - contact code sits in bits 7 and 6 of status byte 0.
// - goto echo mirrors the last written go-to request bit.
// - new finger motion clears any reported object detection.
module gripper_modbus_rtu_slave #(
    parameter int BAUD_RATE = `BAUD_DEFAULT,
    parameter int GAP_CYCLES = `CLK_MHZ * `FRAME_GAP_US,
    parameter int MAX_READ_REGS = `MAX_READ_REGS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // rs-485 line
    input wire logic rs485_rx,
    output logic rs485_tx,
    output logic rs485_tx_en,
    // configuration
    input wire logic [7:0] slave_address,
    // finger motion side
    input wire logic fingers_moving,
    input wire logic contact_stop,
    input wire logic contact_closing,
    input wire logic position_reached,
    input wire logic object_slipped,
    input wire logic [1:0] gripper_state,
    input wire logic [7:0] fault_status,
    input wire logic [7:0] finger_position,
    input wire logic [7:0] motor_current,
    // commands and brake
    output logic brake_engage,
    output logic [7:0] action_request,
    output logic goto_request,
    output logic [7:0] target_position,
    output logic [7:0] speed_setpoint,
    output logic [7:0] force_setpoint
);
    localparam int GAP_W = $clog2(GAP_CYCLES + 1);

    logic rst_meta, rst_sync_n;
    logic rx_valid, tx_start, tx_ready;
    logic [7:0] rx_data, tx_byte;
    gripper_pkg::link_state_e state, next_state;
    logic [7:0] buf_q [`RX_MAX];
    logic [7:0] next_buf [`RX_MAX];
    logic [4:0] rx_len, next_rx_len;
    logic rx_ovf, next_rx_ovf;
    logic [15:0] rx_crc, next_rx_crc, tx_crc, next_tx_crc;
    logic [GAP_W-1:0] gap_cnt, next_gap_cnt;
    logic [5:0] tx_idx, next_tx_idx, resp_len, next_resp_len;
    logic [7:0] cmd [`CMD_BYTES];
    logic [7:0] next_cmd [`CMD_BYTES];
    logic [7:0] stat [`STAT_BYTES];
    logic [7:0] fc, bcnt;
    logic [15:0] rstart, rcnt, wstart, wcnt;
    logic [8:0] exp_len;
    logic has_read, has_write, frame_ok;
    int dofs, off, sidx;
    logic [1:0] obj_state, next_obj_state, pend_code, next_pend_code;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    modbus_uart #(
        .BIT_CYCLES(`CLK_HZ / BAUD_RATE)
    ) u_uart (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .rx_pin(rs485_rx),
        .tx_pin(rs485_tx),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .tx_start(tx_start),
        .tx_data(tx_byte),
        .tx_ready(tx_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // frame decode; fields are taken high byte first
    always_comb begin
        fc = buf_q[1];
        rstart = {buf_q[2], buf_q[3]};
        rcnt = {buf_q[4], buf_q[5]};
        wstart = {buf_q[2], buf_q[3]};
        wcnt = {buf_q[4], buf_q[5]};
        bcnt = buf_q[6];
        dofs = 7;
        exp_len = 9'd8;
        has_read = 1'b0;
        has_write = 1'b0;
        unique case (fc)
            `FC_READ_INPUT: begin
                has_read = 1'b1;
            end
            `FC_PRESET_MULTI: begin
                has_write = 1'b1;
                exp_len = 9'({1'b0, bcnt} + 9'd9);
            end
            `FC_READ_WRITE: begin
                has_read = 1'b1;
                has_write = 1'b1;
                wstart = {buf_q[6], buf_q[7]};
                wcnt = {buf_q[8], buf_q[9]};
                bcnt = buf_q[10];
                dofs = 11;
                exp_len = 9'({1'b0, bcnt} + 9'd13);
            end
            default: begin
                // other functions are dropped silently, no exception reply
                exp_len = 9'd0;
            end
        endcase
        // crc over the frame and its own crc leaves a zero residue
        frame_ok = !rx_ovf && rx_len >= 5'd4 && buf_q[0] == slave_address
            && rx_crc == 16'h0000 && exp_len == {4'h0, rx_len};
        if (has_read && (rcnt == 16'h0000 || rcnt > 16'(MAX_READ_REGS))) begin
            frame_ok = 1'b0;
        end
        if (has_write && {8'h00, bcnt} != {wcnt[14:0], 1'b0}) begin
            frame_ok = 1'b0;
        end
    end

    // status image: two bytes per register, byte 0 first
    always_comb begin
        stat[0] = 8'h00;
        stat[0][`OBJ_LSB +: 2] = obj_state;
        stat[0][`STA_LSB +: 2] = gripper_state;
        stat[0][`BIT_GOTO] = goto_request;
        stat[0][`BIT_ACT] = action_request[`BIT_ACT];
        stat[1] = 8'h00;
        stat[2] = fault_status;
        stat[3] = target_position;
        stat[4] = finger_position;
        stat[5] = motor_current;
    end

    // reply byte for the current index; data bytes leave in byte order
    always_comb begin
        sidx = 2 * (int'(rstart) - int'(`STAT_BASE)) + int'(tx_idx) - 3;
        if (tx_idx == resp_len - 6'd2) begin
            tx_byte = tx_crc[7:0];
        end else if (tx_idx == resp_len - 6'd1) begin
            tx_byte = tx_crc[15:8];
        end else if (tx_idx == 6'd0) begin
            tx_byte = slave_address;
        end else if (tx_idx == 6'd1) begin
            tx_byte = fc;
        end else if (!has_read) begin
            tx_byte = buf_q[5'(tx_idx)];
        end else if (tx_idx == 6'd2) begin
            tx_byte = {rcnt[6:0], 1'b0};
        end else if (sidx >= 0 && sidx < `STAT_BYTES) begin
            tx_byte = stat[sidx];
        end else begin
            tx_byte = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        next_buf = buf_q;
        next_rx_len = rx_len;
        next_rx_ovf = rx_ovf;
        next_rx_crc = rx_crc;
        next_gap_cnt = gap_cnt;
        next_tx_idx = tx_idx;
        next_resp_len = resp_len;
        next_tx_crc = tx_crc;
        next_cmd = cmd;
        tx_start = 1'b0;
        off = 0;
        unique case (state)
            gripper_pkg::st_idle: begin
                if (rx_valid) begin
                    next_gap_cnt = '0;
                    next_rx_crc = gripper_pkg::crc_step(rx_crc, rx_data);
                    if (rx_len < 5'(`RX_MAX)) begin
                        next_buf[rx_len] = rx_data;
                        next_rx_len = rx_len + 5'd1;
                    end else begin
                        next_rx_ovf = 1'b1;
                    end
                end else if (rx_len != 5'd0) begin
                    // line silence closes the frame
                    if (gap_cnt == GAP_W'(GAP_CYCLES - 1)) begin
                        next_state = gripper_pkg::st_exec;
                    end else begin
                        next_gap_cnt = gap_cnt + 1'b1;
                    end
                end
            end
            gripper_pkg::st_exec: begin
                next_rx_len = 5'd0;
                next_rx_ovf = 1'b0;
                next_rx_crc = `CRC_INIT;
                next_gap_cnt = '0;
                next_tx_idx = 6'd0;
                next_tx_crc = `CRC_INIT;
                next_resp_len = has_read ? 6'(16'd5 + {rcnt[14:0], 1'b0}) : 6'd8;
                next_state = frame_ok ? gripper_pkg::st_send : gripper_pkg::st_idle;
                // writes land before the reply; reserved bytes 1 and 2 are not kept
                if (frame_ok && has_write) begin
                    for (int i = 0; i < `CMD_BYTES; i++) begin
                        off = i - 2 * (int'(wstart) - int'(`CMD_BASE));
                        if (i != 1 && i != 2 && off >= 0 && off < 2 * int'(wcnt)
                            && dofs + off < `RX_MAX) begin
                            next_cmd[i] = buf_q[dofs + off];
                        end
                    end
                end
            end
            gripper_pkg::st_send: begin
                if (tx_ready) begin
                    tx_start = 1'b1;
                    next_tx_idx = tx_idx + 6'd1;
                    if (tx_idx < resp_len - 6'd2) begin
                        next_tx_crc = gripper_pkg::crc_step(tx_crc, tx_byte);
                    end
                    if (tx_idx == resp_len - 6'd1) begin
                        next_state = gripper_pkg::st_wait;
                    end
                end
            end
            gripper_pkg::st_wait: begin
                if (tx_ready) begin
                    next_state = gripper_pkg::st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= gripper_pkg::st_idle;
            for (int i = 0; i < `RX_MAX; i++) begin
                buf_q[i] <= 8'h00;
            end
            for (int i = 0; i < `CMD_BYTES; i++) begin
                cmd[i] <= `CMD_RESET;
            end
            rx_len <= 5'd0;
            rx_ovf <= 1'b0;
            rx_crc <= `CRC_INIT;
            gap_cnt <= '0;
            tx_idx <= 6'd0;
            resp_len <= 6'd8;
            tx_crc <= `CRC_INIT;
        end else begin
            state <= next_state;
            buf_q <= next_buf;
            cmd <= next_cmd;
            rx_len <= next_rx_len;
            rx_ovf <= next_rx_ovf;
            rx_crc <= next_rx_crc;
            gap_cnt <= next_gap_cnt;
            tx_idx <= next_tx_idx;
            resp_len <= next_resp_len;
            tx_crc <= next_tx_crc;
        end
    end

    // half duplex: the driver is on only while a reply is on the line
    assign rs485_tx_en = state == gripper_pkg::st_send || state == gripper_pkg::st_wait;
    assign action_request = cmd[0];
    assign goto_request = cmd[0][`BIT_GOTO];
    assign target_position = cmd[`BYTE_TARGET];
    assign speed_setpoint = cmd[`BYTE_SPEED];
    assign force_setpoint = cmd[`BYTE_FORCE];

    ////////////////////////////////////////////////////////////////////////////
    // contact code and brake; the code waits one cycle behind the brake
    logic pend, next_pend, next_brake;

    always_comb begin
        next_obj_state = obj_state;
        next_pend = 1'b0;
        next_pend_code = pend_code;
        next_brake = brake_engage;
        if (contact_stop || position_reached) begin
            next_brake = 1'b1;
            next_pend = 1'b1;
            next_pend_code = position_reached ? `OBJ_AT_TARGET
                : (contact_closing ? `OBJ_STOP_CLOSE : `OBJ_STOP_OPEN);
        end else if (fingers_moving) begin
            next_brake = 1'b0;
            next_obj_state = `OBJ_MOVING;
        end else if (pend) begin
            next_obj_state = pend_code;
        end else if (object_slipped && obj_state == `OBJ_STOP_CLOSE) begin
            next_obj_state = `OBJ_AT_TARGET;
        end
        if (!goto_request) begin
            next_obj_state = `OBJ_MOVING;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            obj_state <= `OBJ_MOVING;
            pend <= 1'b0;
            pend_code <= `OBJ_MOVING;
            brake_engage <= 1'b1;
        end else begin
            obj_state <= next_obj_state;
            pend <= next_pend;
            pend_code <= next_pend_code;
            brake_engage <= next_brake;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_sync_n);

    sequence close_contact_s;
        goto_request && contact_stop && contact_closing && !position_reached;
    endsequence
    sequence settle_s;
        goto_request && !contact_stop && !position_reached && !fingers_moving;
    endsequence

    chk_close_code: assert property (close_contact_s ##1 settle_s |=> obj_state == 2'h2)
        else $error("closing contact did not report code 2");
    chk_brake_first: assert property (
        obj_state != $past(obj_state) && (obj_state == 2'h1 || obj_state == 2'h2)
        |-> $past(brake_engage) && brake_engage)
        else $error("contact reported without brake engaged");
    chk_slip_three: assert property (
        (obj_state == 2'h2 && !pend && object_slipped) and settle_s |=> obj_state == 2'h3)
        else $error("slip after closing contact not reported");
    chk_motion_clears: assert property (
        fingers_moving && !contact_stop && !position_reached |=> obj_state == 2'h0
        && !brake_engage)
        else $error("motion did not clear contact code");
    chk_echo_gates: assert property (!goto_request |=> obj_state == 2'h0)
        else $error("contact code set while go-to echo is zero");
    chk_bad_quiet: assert property (
        state == gripper_pkg::st_exec && !frame_ok |=> !rs485_tx_en [*8])
        else $error("reply driven for a dropped frame");
    chk_reply_addr: assert property (
        tx_start && tx_idx == 6'd0 |-> tx_byte == slave_address && rs485_tx_en)
        else $error("reply does not open with slave address");
    chk_read_count: assert property (
        tx_start && tx_idx == 6'd2 && has_read |-> tx_byte == 8'(2 * rcnt))
        else $error("read reply byte count wrong");
    chk_crc_tail: assert property (
        tx_start && tx_idx == resp_len - 6'd1 |-> tx_byte == tx_crc[15:8]
        ##1 state == gripper_pkg::st_wait)
        else $error("reply does not end with crc high byte");
endmodule : gripper_modbus_rtu_slave

// ===== modbus_master_model.sv
// modbus master model: sends request frames and collects replies
`timescale 1ns/1ns
module modbus_master_model #(
    parameter int BIT_CYCLES = 10
) (
    // clock
    input wire logic clk_sys,
    // rs-485 pair, master side
    output logic line_out,
    input wire logic line_in,
    input wire logic line_en
);
    logic [7:0] rq[$];

    // idle high: the bus bias holds the pair at mark between frames
    initial line_out = 1'b1;

    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
            end
        end
        return c;
    endfunction : crc16

    task automatic put_byte(input logic [7:0] b);
        logic [9:0] sh;
        sh = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= sh[i];
            repeat (BIT_CYCLES) @(posedge clk_sys);
        end
    endtask : put_byte

    // bad flips one crc bit so the slave must drop the frame
    task automatic send_frame(input logic [7:0] req[$], input logic bad);
        logic [15:0] c;
        c = crc16(req) ^ {15'h0000, bad};
        req.push_back(c[7:0]);
        req.push_back(c[15:8]);
        @(posedge clk_sys);
        foreach (req[i]) put_byte(req[i]);
    endtask : send_frame

    // a missing byte leaves rq short, which the bench reports
    task automatic get_frame(input int n);
        logic [7:0] b;
        int t;
        rq.delete();
        for (int j = 0; j < n; j++) begin
            t = 0;
            while (!(line_in === 1'b0 && line_en === 1'b1) && t < 4000) begin
                @(posedge clk_sys);
                t++;
            end
            if (t >= 4000) return;
            repeat (BIT_CYCLES + BIT_CYCLES / 2) @(posedge clk_sys);
            for (int i = 0; i < 8; i++) begin
                b[i] = line_in;
                repeat (BIT_CYCLES) @(posedge clk_sys);
            end
            rq.push_back(b);
        end
    endtask : get_frame
endmodule : modbus_master_model

// ===== gripper_modbus_rtu_slave_tb_top.sv
// self-checking bench for the gripper modbus rtu slave
`timescale 1ns/1ns
module gripper_modbus_rtu_slave_tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic rs485_rx, rs485_tx, rs485_tx_en, brake_engage, goto_request;
    logic fingers_moving = 1'b0, contact_stop = 1'b0, contact_closing = 1'b0;
    logic position_reached = 1'b0, object_slipped = 1'b0;
    logic [7:0] action_request, target_position, speed_setpoint, force_setpoint;
    logic [7:0] slave_address, fault_status, finger_position, motor_current;
    logic [1:0] gripper_state;
    logic [7:0] b0[7] = '{8'h39, 8'hb9, 8'hf9, 8'h39, 8'h79, 8'h39, 8'hf9};
    int ev[7] = '{0, 1, 3, 0, 2, 0, 4};
    int n_errors = 0, num_checks = 0, cycles = 0;

    // 10-cycle bits; the gap counts from each byte's end, so it must outlast a 100-cycle byte
    gripper_modbus_rtu_slave #(.BAUD_RATE(12500000), .GAP_CYCLES(350)) u_gripper_modbus_rtu_slave (
        .clk_sys(clk_sys), .rst_n(rst_n), .rs485_rx(rs485_rx), .rs485_tx(rs485_tx),
        .rs485_tx_en(rs485_tx_en), .slave_address(slave_address),
        .fingers_moving(fingers_moving),
        .contact_stop(contact_stop), .contact_closing(contact_closing),
        .position_reached(position_reached), .object_slipped(object_slipped),
        .gripper_state(gripper_state), .fault_status(fault_status),
        .finger_position(finger_position), .motor_current(motor_current),
        .brake_engage(brake_engage), .action_request(action_request),
        .goto_request(goto_request), .target_position(target_position),
        .speed_setpoint(speed_setpoint), .force_setpoint(force_setpoint));

    modbus_master_model #(.BIT_CYCLES(10)) u_modbus_master_model (
        .clk_sys(clk_sys), .line_out(rs485_rx), .line_in(rs485_tx), .line_en(rs485_tx_en));

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 80000) begin
            n_errors++;
            end_sim();
        end
    end

    // reply bytes compared one by one, then the crc residue must be zero
    task automatic xfer(input logic [7:0] req[$], input logic [7:0] exp[$]);
        u_modbus_master_model.send_frame(req, 1'b0);
        u_modbus_master_model.get_frame(exp.size() + 2);
        check(u_modbus_master_model.rq.size(), exp.size() + 2);
        foreach (exp[i]) check(u_modbus_master_model.rq[i], exp[i]);
        check(u_modbus_master_model.crc16(u_modbus_master_model.rq), 16'h0000);
        // request spacing scaled down with the bit time
        repeat (30) @(posedge clk_sys);
    endtask : xfer

    task automatic silent(input logic [7:0] req[$], input logic bad);
        logic seen;
        seen = 1'b0;
        u_modbus_master_model.send_frame(req, bad);
        repeat (400) begin
            @(posedge clk_sys);
            seen = seen | rs485_tx_en;
        end
        check(seen, 1'b0);
    endtask : silent

    // 0 move, 1 stop closing, 2 stop opening, 3 slip, 4 reached
    task automatic motion(input int k);
        @(posedge clk_sys);
        fingers_moving <= (k == 0);
        contact_stop <= (k == 1 || k == 2);
        contact_closing <= (k == 1);
        object_slipped <= (k == 3);
        position_reached <= (k == 4);
        @(posedge clk_sys);
        contact_stop <= 1'b0;
        object_slipped <= 1'b0;
        position_reached <= 1'b0;
        @(negedge clk_sys);
        check(brake_engage, k != 0);
    endtask : motion

    initial begin
        slave_address <= 8'h09;
        gripper_state <= 2'h3;
        fault_status <= 8'h05;
        finger_position <= 8'ha5;
        motor_current <= 8'h3c;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk_sys);
        xfer({8'h09, 8'h10, 8'h03, 8'he9, 8'h00, 8'h02, 8'h04, 8'h60, 8'he6, 8'h3c, 8'hc8},
            {8'h09, 8'h10, 8'h03, 8'he9, 8'h00, 8'h02});
        check({target_position, speed_setpoint}, 16'he63c);
        check(force_setpoint, 8'hc8);
        xfer({8'h09, 8'h10, 8'h03, 8'he8, 8'h00, 8'h01, 8'h02, 8'h09, 8'h00},
            {8'h09, 8'h10, 8'h03, 8'he8, 8'h00, 8'h01});
        check({action_request, 7'h00, goto_request}, 16'h0901);
        for (int i = 0; i < 7; i++) begin
            motion(ev[i]);
            xfer({8'h09, 8'h04, 8'h07, 8'hd0, 8'h00, 8'h01},
                {8'h09, 8'h04, 8'h02, b0[i], 8'h00});
        end
        xfer({8'h09, 8'h04, 8'h07, 8'hd0, 8'h00, 8'h03},
            {8'h09, 8'h04, 8'h06, 8'hf9, 8'h00, 8'h05, 8'he6, 8'ha5, 8'h3c});
        xfer({8'h09, 8'h10, 8'h03, 8'he8, 8'h00, 8'h01, 8'h02, 8'h01, 8'h00},
            {8'h09, 8'h10, 8'h03, 8'he8, 8'h00, 8'h01});
        xfer({8'h09, 8'h04, 8'h07, 8'hd0, 8'h00, 8'h01},
            {8'h09, 8'h04, 8'h02, 8'h31, 8'h00});
        silent({8'h0a, 8'h04, 8'h07, 8'hd0, 8'h00, 8'h01}, 1'b0);
        silent({8'h09, 8'h04, 8'h07, 8'hd0, 8'h00, 8'h01}, 1'b1);
        silent({8'h09, 8'h03, 8'h07, 8'hd0, 8'h00, 8'h01}, 1'b0);
        xfer({8'h09, 8'h17, 8'h07, 8'hd0, 8'h00, 8'h02, 8'h03, 8'he9, 8'h00, 8'h02, 8'h04,
            8'h00, 8'h7f, 8'h3c, 8'hc8},
            {8'h09, 8'h17, 8'h04, 8'h31, 8'h00, 8'h05, 8'h7f});
        check(target_position, 8'h7f);
        slave_address <= 8'h21;
        xfer({8'h21, 8'h04, 8'h07, 8'hd1, 8'h00, 8'h01},
            {8'h21, 8'h04, 8'h02, 8'h05, 8'h7f});
        end_sim();
    end
endmodule : gripper_modbus_rtu_slave_tb_top
